/* File: verilog/psc_pkg.sv */
package psc_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_SERIAL_CFG    = 8'h3d;
    localparam logic [7:0] ADDR_PRODUCT_ID    = 8'h3e;
    localparam logic [7:0] ADDR_I2C_ADDR      = 8'h3f;
    localparam logic [7:0] ADDR_DSP_FILTER    = 8'h40;
    localparam logic [7:0] ADDR_DSP_DATA_TYPE = 8'h42;
    localparam logic [7:0] ADDR_DSP_SELFTEST  = 8'h44;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_SERIAL_CFG    = 8'h00;
    localparam logic [7:0] RST_PRODUCT_ID    = 8'h00;
    localparam logic [7:0] RST_I2C_ADDR      = 8'h00;
    localparam logic [7:0] RST_DSP_FILTER    = 8'h30;
    localparam logic [7:0] RST_DSP_DATA_TYPE = 8'h00;
    localparam logic [7:0] RST_DSP_SELFTEST  = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DATA_WIDTH_BIT = 6;
    localparam int CRC_LEN_MSB    = 5;
    localparam int CRC_LEN_LSB    = 4;
    localparam int CRC_SEED_MSB   = 3;
    localparam int CRC_SEED_LSB   = 0;
    localparam int FILTER_MSB     = 7;
    localparam int FILTER_LSB     = 4;
    localparam int SLOT0_MSB      = 6;
    localparam int SLOT0_LSB      = 5;
    localparam int SLOT1_MSB      = 3;
    localparam int SLOT1_LSB      = 2;
    localparam int SELFTEST_MSB   = 3;
    localparam int SELFTEST_LSB   = 0;

    // ************************************************************
    // field codes and substitute values
    // ************************************************************
    localparam logic [3:0] FILTER_800HZ     = 4'h2;
    localparam logic [3:0] FILTER_1000HZ    = 4'h3;
    localparam logic [1:0] KIND_PRESSURE    = 2'h1;
    localparam logic [1:0] KIND_TEMPERATURE = 2'h3;
    localparam logic [1:0] CRC_LEN_8        = 2'h0;
    localparam logic [1:0] CRC_LEN_4        = 2'h1;
    // arbitrary identifier value returned while the stored value is zero
    localparam logic [7:0] PRODUCT_ID_READ  = 8'h5a;
    localparam logic [7:0] I2C_DEFAULT_ADDR = 8'h60;
    // polynomials without the leading term
    localparam logic [7:0] CRC_POLY_8       = 8'h2f;
    localparam logic [7:0] CRC_POLY_4       = 8'h01;
    localparam logic [7:0] CRC_POLY_3       = 8'h03;
    localparam logic [7:0] CRC_SEED_8       = 8'hff;
    localparam logic [7:0] CRC_SEED_4       = 8'h0a;
    localparam logic [7:0] CRC_SEED_3       = 8'h07;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLOCK_PERIOD_NS = 40;
    localparam int unsigned DSP_INIT_NS     = 40000;
    localparam int unsigned DSP_INIT_CYCLES =
        (DSP_INIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {CRC_WIDTH_8, CRC_WIDTH_4, CRC_WIDTH_3} psc_crc_width_type;
    typedef enum logic {DSP_RUN, DSP_INIT} psc_dsp_state_type;

endpackage

/* File: verilog/psc_user_config_regs.sv */
`timescale 1ns/1ps
// Operation
// - data width bit clear gives 12-bit data field, set gives 16-bit
// - zero length and seed give 8-bit CRC, polynomial 2Fh, seed FFh
// - length 00 gives 8-bit, 01 gives x^4+1, 10 or 11 give x^3+x+1
// - zero seed gives 1010 or 111; nonzero seed replaces the default
// - CRC length and seed changes apply from the next serial command
// - identifier stores 00h after reset; 00h reads as fixed identifier
// - client address zero answers address 60h and reads back 60h
// - nonzero client address uses low seven bits and reads stored value
// - client address register is readable in every interface mode
// - configuration registers are in the array check, self-test bits excluded
// - writes changing the filter or data type register restart the DSP path; data invalid meanwhile
// - filter code 0010 selects 800 Hz, 0011 selects 1000 Hz default
// - any other filter code flags an error in device status
// - power-on reset returns the filter to its 1000 Hz default
// - slot 0 kind at bits 6:5: 01 pressure, 11 temperature
// - data type register reads and writes in both modes, resets to zero
// - slot 1 kind at bits 3:2: 01 pressure, 11 temperature
// - serial config holds width bit 6, length 5:4, seed 3:0, reset zero
// - while the init lock is set all register writes are ignored
module psc_user_config_regs (
    // clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_rstn,
    // register access
    input  wire logic                       i_reg_write,
    input  wire logic                       i_reg_read,
    input  wire logic [7:0]                 i_reg_addr,
    input  wire logic [7:0]                 i_reg_wdata,
    output logic      [7:0]                 o_reg_rdata,
    output logic                            o_reg_rvalid,
    // serial front end
    input  wire logic                       i_cmd_start,
    input  wire logic                       i_init_done_lock,
    output logic                            o_data_width_16,
    output psc_pkg::psc_crc_width_type      o_crc_width,
    output logic      [7:0]                 o_crc_poly,
    output logic      [7:0]                 o_crc_seed,
    output logic      [6:0]                 o_i2c_client_addr,
    // dsp configuration
    output logic                            o_filter_800hz,
    output logic                            o_filter_error,
    output logic      [1:0]                 o_slot0_kind,
    output logic      [1:0]                 o_slot1_kind,
    output logic      [3:0]                 o_selftest_sel,
    output logic                            o_dsp_restart,
    output logic                            o_sensor_valid,
    output logic                            o_array_error
);
    import psc_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_reg;
    logic rstn_reg;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_reg <= 1'b0;
            rstn_reg     <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rstn_reg     <= rst_meta_reg;
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] crc_poly_of(input logic [1:0] len);
        if (len == CRC_LEN_8) begin
            crc_poly_of = CRC_POLY_8;
        end else if (len == CRC_LEN_4) begin
            crc_poly_of = CRC_POLY_4;
        end else begin
            crc_poly_of = CRC_POLY_3;
        end
    endfunction

    function automatic logic [7:0] crc_seed_of(input logic [1:0] len, input logic [3:0] seed);
        if (len == CRC_LEN_8) begin
            crc_seed_of = (seed == 4'h0) ? CRC_SEED_8 : {4'h0, seed};
        end else if (len == CRC_LEN_4) begin
            crc_seed_of = (seed == 4'h0) ? CRC_SEED_4 : {4'h0, seed};
        end else begin
            crc_seed_of = (seed == 4'h0) ? CRC_SEED_3 : {5'h00, seed[2:0]};
        end
    endfunction

    function automatic logic filter_code_ok(input logic [3:0] code);
        filter_code_ok = (code == FILTER_800HZ) || (code == FILTER_1000HZ);
    endfunction

    // self-test selection bits stay out of the signature
    function automatic logic covered_parity(input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] c, input logic [7:0] d,
                                            input logic [7:0] e, input logic [7:0] f);
        covered_parity = ^{a, b, c, d, e, f[7:SELFTEST_MSB+1]};
    endfunction

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0]        serial_cfg_reg,  serial_cfg_next;
    logic [7:0]        product_id_reg,  product_id_next;
    logic [7:0]        i2c_addr_reg,    i2c_addr_next;
    logic [7:0]        dsp_filter_reg,  dsp_filter_next;
    logic [7:0]        dsp_type_reg,    dsp_type_next;
    logic [7:0]        selftest_reg,    selftest_next;
    logic              signature_reg,   signature_next;
    logic              wr_ok;
    logic              dsp_change;

    always_comb begin
        serial_cfg_next = serial_cfg_reg;
        product_id_next = product_id_reg;
        i2c_addr_next   = i2c_addr_reg;
        dsp_filter_next = dsp_filter_reg;
        dsp_type_next   = dsp_type_reg;
        selftest_next   = selftest_reg;
        wr_ok           = i_reg_write && !i_init_done_lock;
        if (wr_ok) begin
            if (i_reg_addr == ADDR_SERIAL_CFG) begin
                serial_cfg_next = i_reg_wdata;
            end else if (i_reg_addr == ADDR_PRODUCT_ID) begin
                product_id_next = i_reg_wdata;
            end else if (i_reg_addr == ADDR_I2C_ADDR) begin
                i2c_addr_next = i_reg_wdata;
            end else if (i_reg_addr == ADDR_DSP_FILTER) begin
                dsp_filter_next = i_reg_wdata;
            end else if (i_reg_addr == ADDR_DSP_DATA_TYPE) begin
                dsp_type_next = i_reg_wdata;
            end else if (i_reg_addr == ADDR_DSP_SELFTEST) begin
                selftest_next = i_reg_wdata;
            end
        end
        dsp_change = (dsp_filter_next != dsp_filter_reg) || (dsp_type_next != dsp_type_reg);
        signature_next = covered_parity(serial_cfg_next, product_id_next, i2c_addr_next,
                                        dsp_filter_next, dsp_type_next, selftest_next);
    end

    always_ff @(posedge i_clock or negedge rstn_reg) begin
        if (!rstn_reg) begin
            serial_cfg_reg <= RST_SERIAL_CFG;
            product_id_reg <= RST_PRODUCT_ID;
            i2c_addr_reg   <= RST_I2C_ADDR;
            dsp_filter_reg <= RST_DSP_FILTER;
            dsp_type_reg   <= RST_DSP_DATA_TYPE;
            selftest_reg   <= RST_DSP_SELFTEST;
            signature_reg  <= 1'b0;
        end else begin
            serial_cfg_reg <= serial_cfg_next;
            product_id_reg <= product_id_next;
            i2c_addr_reg   <= i2c_addr_next;
            dsp_filter_reg <= dsp_filter_next;
            dsp_type_reg   <= dsp_type_next;
            selftest_reg   <= selftest_next;
            signature_reg  <= signature_next;
        end
    end

    // ************************************************************
    // read path and decoded outputs
    // ************************************************************
    logic [7:0]        rdata_next;
    logic [1:0]        crc_len;
    psc_crc_width_type crc_width_next;
    logic [7:0]        crc_poly_next;
    logic [7:0]        crc_seed_next;
    logic              array_error_next;

    always_comb begin
        rdata_next = o_reg_rdata;
        if (i_reg_read) begin
            if (i_reg_addr == ADDR_SERIAL_CFG) begin
                rdata_next = serial_cfg_reg;
            end else if (i_reg_addr == ADDR_PRODUCT_ID) begin
                rdata_next = (product_id_reg == 8'h00) ? PRODUCT_ID_READ : product_id_reg;
            end else if (i_reg_addr == ADDR_I2C_ADDR) begin
                rdata_next = (i2c_addr_reg == 8'h00) ? I2C_DEFAULT_ADDR : i2c_addr_reg;
            end else if (i_reg_addr == ADDR_DSP_FILTER) begin
                rdata_next = dsp_filter_reg;
            end else if (i_reg_addr == ADDR_DSP_DATA_TYPE) begin
                rdata_next = dsp_type_reg;
            end else if (i_reg_addr == ADDR_DSP_SELFTEST) begin
                rdata_next = selftest_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
        // crc settings are sampled only at a command start
        crc_len        = serial_cfg_reg[CRC_LEN_MSB:CRC_LEN_LSB];
        crc_width_next = o_crc_width;
        crc_poly_next  = o_crc_poly;
        crc_seed_next  = o_crc_seed;
        if (i_cmd_start) begin
            crc_poly_next = crc_poly_of(crc_len);
            crc_seed_next = crc_seed_of(crc_len, serial_cfg_reg[CRC_SEED_MSB:CRC_SEED_LSB]);
            if (crc_len == CRC_LEN_8) begin
                crc_width_next = CRC_WIDTH_8;
            end else if (crc_len == CRC_LEN_4) begin
                crc_width_next = CRC_WIDTH_4;
            end else begin
                crc_width_next = CRC_WIDTH_3;
            end
        end
        // sticky until reset
        array_error_next = o_array_error ||
            (covered_parity(serial_cfg_reg, product_id_reg, i2c_addr_reg,
                            dsp_filter_reg, dsp_type_reg, selftest_reg) != signature_reg);
    end

    always_ff @(posedge i_clock or negedge rstn_reg) begin
        if (!rstn_reg) begin
            o_reg_rdata       <= 8'h00;
            o_reg_rvalid      <= 1'b0;
            o_data_width_16   <= 1'b0;
            o_crc_width       <= CRC_WIDTH_8;
            o_crc_poly        <= CRC_POLY_8;
            o_crc_seed        <= CRC_SEED_8;
            o_i2c_client_addr <= I2C_DEFAULT_ADDR[6:0];
            o_filter_800hz    <= 1'b0;
            o_filter_error    <= 1'b0;
            o_slot0_kind      <= 2'h0;
            o_slot1_kind      <= 2'h0;
            o_selftest_sel    <= 4'h0;
            o_array_error     <= 1'b0;
        end else begin
            o_reg_rdata       <= rdata_next;
            o_reg_rvalid      <= i_reg_read;
            o_data_width_16   <= serial_cfg_reg[DATA_WIDTH_BIT];
            o_crc_width       <= crc_width_next;
            o_crc_poly        <= crc_poly_next;
            o_crc_seed        <= crc_seed_next;
            o_i2c_client_addr <= (i2c_addr_reg == 8'h00) ? I2C_DEFAULT_ADDR[6:0]
                                                          : i2c_addr_reg[6:0];
            o_filter_800hz    <= dsp_filter_reg[FILTER_MSB:FILTER_LSB] == FILTER_800HZ;
            o_filter_error    <= !filter_code_ok(dsp_filter_reg[FILTER_MSB:FILTER_LSB]);
            o_slot0_kind      <= dsp_type_reg[SLOT0_MSB:SLOT0_LSB];
            o_slot1_kind      <= dsp_type_reg[SLOT1_MSB:SLOT1_LSB];
            o_selftest_sel    <= selftest_reg[SELFTEST_MSB:SELFTEST_LSB];
            o_array_error     <= array_error_next;
        end
    end

    // ************************************************************
    // dsp restart sequencing
    // ************************************************************
    psc_dsp_state_type dsp_state_reg, dsp_state_next;
    logic [9:0]        init_count_reg, init_count_next;

    always_comb begin
        dsp_state_next  = dsp_state_reg;
        init_count_next = init_count_reg;
        case (dsp_state_reg)
            DSP_RUN: begin
                init_count_next = 10'h000;
            end
            DSP_INIT: begin
                init_count_next = init_count_reg + 10'h001;
                if (init_count_reg == 10'(DSP_INIT_CYCLES - 1)) begin
                    dsp_state_next = DSP_RUN;
                end
            end
            default: dsp_state_next = DSP_RUN;
        endcase
        if (dsp_change) begin
            dsp_state_next  = DSP_INIT;
            init_count_next = 10'h000;
        end
    end

    always_ff @(posedge i_clock or negedge rstn_reg) begin
        if (!rstn_reg) begin
            dsp_state_reg  <= DSP_RUN;
            init_count_reg <= 10'h000;
            o_dsp_restart  <= 1'b0;
            o_sensor_valid <= 1'b1;
        end else begin
            dsp_state_reg  <= dsp_state_next;
            init_count_reg <= init_count_next;
            o_dsp_restart  <= dsp_change;
            o_sensor_valid <= dsp_state_next == DSP_RUN;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rstn_reg);

    dsp_restart_a: assert property (dsp_change |=> o_dsp_restart && !o_sensor_valid)
        else $error("dsp change did not restart the data path");
    init_hold_a: assert property ($rose(o_dsp_restart) |-> !o_sensor_valid [*8])
        else $error("sensor data valid too early after restart");
    crc_hold_a: assert property (
        !$past(i_cmd_start) |-> $stable(o_crc_seed) && $stable(o_crc_poly))
        else $error("crc settings changed outside a command start");
    crc_default_a: assert property (
        i_cmd_start && serial_cfg_reg[5:0] == 6'h00
        |=> o_crc_poly == 8'h2f && o_crc_seed == 8'hff)
        else $error("default crc is not 8-bit with seed ff");
    crc_three_a: assert property (
        i_cmd_start && serial_cfg_reg[5] && serial_cfg_reg[3:0] == 4'h0
        |=> o_crc_width == CRC_WIDTH_3 && o_crc_seed == 8'h07)
        else $error("3-bit crc default seed wrong");
    i2c_default_a: assert property (i2c_addr_reg == 8'h00 |=> o_i2c_client_addr == 7'h60)
        else $error("zero client address does not answer 60h");
    id_read_a: assert property (
        i_reg_read && i_reg_addr == ADDR_PRODUCT_ID && product_id_reg == 8'h00
        |=> o_reg_rvalid && o_reg_rdata == PRODUCT_ID_READ)
        else $error("zero identifier does not read as fixed value");
    write_lock_a: assert property (
        i_init_done_lock |=> $stable(dsp_filter_reg) && $stable(serial_cfg_reg))
        else $error("register written after init lock");
    filter_error_a: assert property (
        dsp_filter_reg[7:4] != 4'h2 && dsp_filter_reg[7:4] != 4'h3 |=> o_filter_error)
        else $error("bad filter code not flagged");
    width_sel_a: assert property (##1 o_data_width_16 == $past(serial_cfg_reg[6]))
        else $error("data width output does not follow bit 6");

    restart_seen_c: cover property (o_dsp_restart ##1 !o_sensor_valid);
    id_custom_c: cover property (
        i_reg_read && i_reg_addr == ADDR_PRODUCT_ID && product_id_reg != 8'h00);
    crc_four_c: cover property (i_cmd_start && serial_cfg_reg[5:4] == 2'h1);

endmodule

/* File: test/psc_host_model.sv */
`timescale 1ns/1ps
module psc_host_model (
    // clock and status
    input  wire logic       i_clock,
    input  wire logic       i_sensor_valid,
    // register access
    output logic            o_reg_write,
    output logic            o_reg_read,
    output logic [7:0]      o_reg_addr,
    output logic [7:0]      o_reg_wdata,
    output logic            o_cmd_start,
    // read answer
    input  wire logic [7:0] i_reg_rdata,
    input  wire logic       i_reg_rvalid
);
    initial begin
        o_reg_write = 1'b0;
        o_reg_read  = 1'b0;
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
        o_cmd_start = 1'b0;
    end
    // released bus shows the inverse of its last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock) #1;
        o_reg_write = 1'b1;
        o_reg_addr  = a;
        o_reg_wdata = d;
        @(posedge i_clock) #1;
        o_reg_write = 1'b0;
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
        @(posedge i_clock) #1;
        o_reg_read = 1'b1;
        o_reg_addr = a;
        @(posedge i_clock) #1;
        o_reg_read = 1'b0;
        o_reg_addr = ~a;
        q = i_reg_rdata;
        v = i_reg_rvalid;
    endtask
    task automatic cmd();
        @(posedge i_clock) #1;
        o_cmd_start = 1'b1;
        @(posedge i_clock) #1;
        o_cmd_start = 1'b0;
    endtask
    // no sensor traffic until the dsp path is back up
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 1100 && !ok; i++) begin
            @(posedge i_clock) #1;
            ok = i_sensor_valid;
        end
    endtask
endmodule

/* File: test/tb_psc_user_config_regs.sv */
`timescale 1ns/1ps
module tb_psc_user_config_regs;
    import psc_pkg::*;
    logic i_clock, i_rstn, i_init_done_lock, w, r, cs, rv, w16, f8, fe, rs, sv, ae, ok, v;
    logic [7:0] ad, wd, rdat, poly, seed, got, e_p, e_s, x;
    logic [6:0] i2ca;
    logic [1:0] k0, k1;
    logic [3:0] st;
    psc_crc_width_type cw, e_w;
    logic [7:0] mdl [int];
    logic [7:0] fseq [6] = '{8'h20, 8'h30, 8'h30, 8'h50, 8'hf3, 8'h30};
    int n_fail = 0;
    int n_checks = 0;
    psc_user_config_regs psc_user_config_regs_inst (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_reg_write(w), .i_reg_read(r), .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat),
        .o_reg_rvalid(rv), .i_cmd_start(cs), .i_init_done_lock(i_init_done_lock),
        .o_data_width_16(w16), .o_crc_width(cw), .o_crc_poly(poly), .o_crc_seed(seed),
        .o_i2c_client_addr(i2ca), .o_filter_800hz(f8), .o_filter_error(fe), .o_slot0_kind(k0),
        .o_slot1_kind(k1), .o_selftest_sel(st), .o_dsp_restart(rs), .o_sensor_valid(sv),
        .o_array_error(ae));
    psc_host_model psc_host_model_inst (.i_clock(i_clock), .i_sensor_valid(sv), .o_reg_write(w),
        .o_reg_read(r), .o_reg_addr(ad), .o_reg_wdata(wd), .o_cmd_start(cs),
        .i_reg_rdata(rdat), .i_reg_rvalid(rv));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string k);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s at %0t: got %h expected %h", k, $time, g, e);
        end
    endtask
    task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
        cmp(g, e, "read data");
    endtask
    task automatic chk_out(input logic [7:0] g, input logic [7:0] e);
        cmp(g, e, "output");
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (!mdl.exists(a)) return 8'h00;
        if (a == ADDR_PRODUCT_ID && mdl[a] == 8'h00) return PRODUCT_ID_READ;
        if (a == ADDR_I2C_ADDR && mdl[a] == 8'h00) return I2C_DEFAULT_ADDR;
        return mdl[a];
    endfunction
    task automatic do_rd(input logic [7:0] a);
        psc_host_model_inst.rd(a, got, v);
        chk_out({7'h0, v}, 8'h01);
        chk_rd(got, exp_rd(a));
    endtask
    task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
        logic ch;
        ch = !i_init_done_lock && (a == ADDR_DSP_FILTER || a == ADDR_DSP_DATA_TYPE) && mdl[a] != d;
        psc_host_model_inst.wr(a, d);
        if (mdl.exists(a) && !i_init_done_lock) mdl[a] = d;
        chk_out({7'h0, rs}, {7'h0, ch});
        chk_out({7'h0, sv}, {7'h0, !ch});
        repeat (2) @(posedge i_clock);
        #1;
        if (ch) psc_host_model_inst.wait_ready(ok);
        if (ch && !ok) begin
            n_fail++;
            summarize();
        end
    endtask
    initial begin
        i_rstn = 1'b0;
        i_init_done_lock = 1'b0;
        void'($urandom(67195));
        mdl = '{8'h3d: 8'h00, 8'h3e: 8'h00, 8'h3f: 8'h00,
                8'h40: 8'h30, 8'h42: 8'h00, 8'h44: 8'h00};
        repeat (20) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        repeat (4) @(posedge i_clock);
        foreach (mdl[a]) do_rd(8'(a));
        chk_out({cw, poly[5:0]}, {CRC_WIDTH_8, CRC_POLY_8[5:0]});
        chk_out(seed, CRC_SEED_8);
        chk_out({1'b0, i2ca}, I2C_DEFAULT_ADDR);
        $display("test reset done");
        e_s = CRC_SEED_8;
        for (int len = 0; len < 4; len++) begin
            for (int k = 0; k < 2; k++) begin
                x = k ? 8'($urandom % 15 + 1) : 8'h00;
                do_wr(ADDR_SERIAL_CFG, {1'b0, k[0], len[1:0], x[3:0]});
                chk_out(seed, e_s);
                chk_out({7'h0, w16}, 8'(k));
                e_w = len == 0 ? CRC_WIDTH_8 : (len == 1 ? CRC_WIDTH_4 : CRC_WIDTH_3);
                e_p = len == 0 ? CRC_POLY_8 : (len == 1 ? CRC_POLY_4 : CRC_POLY_3);
                if (len == 0) e_s = k ? x : 8'hff;
                else if (len == 1) e_s = k ? x : 8'h0a;
                else e_s = k ? {5'h0, x[2:0]} : 8'h07;
                psc_host_model_inst.cmd();
                chk_out({6'h0, cw}, {6'h0, e_w});
                chk_out(poly, e_p);
                chk_out(seed, e_s);
                do_rd(ADDR_SERIAL_CFG);
            end
        end
        $display("test crc done");
        x = 8'($urandom % 255 + 1);
        do_wr(ADDR_PRODUCT_ID, x);
        do_rd(ADDR_PRODUCT_ID);
        do_wr(ADDR_I2C_ADDR, x);
        chk_out({1'b0, i2ca}, {1'b0, x[6:0]});
        do_rd(ADDR_I2C_ADDR);
        do_wr(ADDR_I2C_ADDR, 8'h00);
        chk_out({1'b0, i2ca}, I2C_DEFAULT_ADDR);
        $display("test identity done");
        foreach (fseq[i]) begin
            x = fseq[i];
            do_wr(ADDR_DSP_FILTER, x);
            chk_out({7'h0, f8}, {7'h0, x[7:4] == FILTER_800HZ});
            chk_out({7'h0, fe}, {7'h0, x[7:4] != FILTER_800HZ && x[7:4] != FILTER_1000HZ});
        end
        for (int i = 0; i < 3; i++) begin
            x = i == 0 ? 8'h24 : (i == 1 ? 8'h6c : 8'($urandom));
            do_wr(ADDR_DSP_DATA_TYPE, x);
            chk_out({6'h0, k0}, {6'h0, x[6:5]});
            chk_out({6'h0, k1}, {6'h0, x[3:2]});
            do_rd(ADDR_DSP_DATA_TYPE);
        end
        x = 8'($urandom);
        do_wr(ADDR_DSP_SELFTEST, x);
        chk_out({4'h0, st}, {4'h0, x[3:0]});
        do_rd(ADDR_DSP_SELFTEST);
        $display("test dsp done");
        do_wr(8'h41, 8'h55);
        do_rd(8'h41);
        i_init_done_lock = 1'b1;
        do_wr(ADDR_I2C_ADDR, 8'h15);
        do_wr(ADDR_DSP_FILTER, 8'h20);
        do_rd(ADDR_I2C_ADDR);
        i_init_done_lock = 1'b0;
        chk_out({7'h0, ae}, 8'h00);
        $display("test lock done");
        do_wr(ADDR_DSP_FILTER, 8'h20);
        i_rstn = 1'b0;
        repeat (2) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        repeat (4) @(posedge i_clock);
        mdl[ADDR_DSP_FILTER] = RST_DSP_FILTER;
        do_rd(ADDR_DSP_FILTER);
        chk_out({7'h0, f8}, 8'h00);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
